// ---- switch_global_control_pkg.sv ----
// Constants, field layout and timing for the global switch control bank.
// Operation
// - Storm threshold is 11 bits from low byte and 3-bit high field, low byte resets 0x63.
// - Storm interval is 67 ms at 100 Mb/s, 670 ms at 10 Mb/s; count restarts each interval.
// - Bit 7 set selects repeater mode; clear (reset) keeps normal switching.
// - Bit 6 set selects host port half duplex, clear selects full duplex.
// - Bit 5, reset 1, enables host port full-duplex pause flow control.
// - Bit 3 set replaces null VLAN ID with the ingress port default VLAN ID.
// - LED mode code is bit 15 (upper) and bit 9 (lower) of LED register.
// - Code 00: link/activity, duplex/collision, speed; 01: 100 link, 10 link, duplex.
package switch_global_control_pkg;
	localparam int ADDR_WIDTH = 16;
	localparam int DATA_WIDTH = 16;
	localparam int STORM_WIDTH = 11;
	localparam int VID_WIDTH = 12;
	localparam int STORM_TIMER_WIDTH = 27;
	localparam logic [15:0] STORM_REPEATER_HOST_PORT_CONTROL_OFFSET = 16'h0406;
	localparam logic [15:0] FACTORY_TEST_CONTROL_OFFSET = 16'h0408;
	localparam logic [15:0] LED_MODE_CHIP_CONTROL_OFFSET = 16'h040a;
	localparam logic [15:0] PORT_STORM_STATUS_OFFSET = 16'h0440;
	localparam logic [15:0] STORM_REPEATER_HOST_PORT_CONTROL_RESET = 16'h6320;
	localparam logic [15:0] FACTORY_TEST_CONTROL_RESET = 16'h2400;
	localparam logic [15:0] LED_MODE_CHIP_CONTROL_RESET = 16'h0835;
	localparam logic [15:0] LED_MODE_WRITE_MASK = 16'hfe00;
	localparam int STORM_LOW_MSB = 15;
	localparam int STORM_LOW_LSB = 8;
	localparam int REPEATER_MODE_BIT = 7;
	localparam int HOST_HALF_DUPLEX_BIT = 6;
	localparam int HOST_FLOW_CONTROL_BIT = 5;
	localparam int NULL_VID_REPLACE_BIT = 3;
	localparam int STORM_HIGH_MSB = 2;
	localparam int LED_MODE_SELECT_HIGH_BIT = 15;
	localparam int LED_MODE_SELECT_LOW_BIT = 9;
	localparam logic [11:0] NULL_VID = 12'h000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int NS_PER_MS = 1000000;
	localparam int STORM_INTERVAL_100M_MS = 67;
	localparam int STORM_INTERVAL_10M_MS = 670;
	localparam int STORM_INTERVAL_100M_CYCLES = STORM_INTERVAL_100M_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int STORM_INTERVAL_10M_CYCLES = STORM_INTERVAL_10M_MS * NS_PER_MS / CLK_PERIOD_NS;
	typedef enum logic [1:0] {
		LED_MODE_LINK_ACT,
		LED_MODE_SPEED_SPLIT,
		LED_MODE_SPARE_2,
		LED_MODE_SPARE_3
	} led_mode_type;
endpackage

// ---- port_ctrl.sv ----
// Per-port storm limiter, null VLAN ID replacement and LED driver.
`timescale 1ns/1ns
module port_ctrl #(
	parameter int INTERVAL_100M_CYCLES = switch_global_control_pkg::STORM_INTERVAL_100M_CYCLES,
	parameter int INTERVAL_10M_CYCLES = switch_global_control_pkg::STORM_INTERVAL_10M_CYCLES
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [10:0] storm_threshold,
	input wire logic null_vid_replace_en,
	input wire switch_global_control_pkg::led_mode_type led_mode,
	input wire logic link_up,
	input wire logic speed_100,
	input wire logic full_duplex,
	input wire logic collision,
	input wire logic activity,
	input wire logic bcast_block_valid,
	input wire logic tag_valid,
	input wire logic [11:0] tag_vid,
	input wire logic [11:0] port_default_vid,
	output logic storm_limited,
	output logic vid_out_valid,
	output logic [11:0] vid_out,
	output logic port_indicator_0,
	output logic port_indicator_1,
	output logic port_indicator_2,
	output logic port_indicator_3
);
	localparam logic [26:0] LAST_100M = 27'(INTERVAL_100M_CYCLES - 1);
	localparam logic [26:0] LAST_10M = 27'(INTERVAL_10M_CYCLES - 1);

	logic [26:0] timer_reg;
	logic [26:0] timer_next;
	logic [10:0] count_reg;
	logic [10:0] count_next;
	logic limited_reg;
	logic limited_next;
	logic interval_end;
	logic vid_valid_reg;
	logic vid_valid_next;
	logic [11:0] vid_reg;
	logic [11:0] vid_next;
	logic [3:0] led_reg;
	logic [3:0] led_next;

	// Comparing with >= lets a speed change from 10 to 100 Mb/s end the long interval at once.
	assign interval_end = timer_reg >= (speed_100 ? LAST_100M : LAST_10M);

	always_comb begin
		timer_next = interval_end ? 27'h0000000 : timer_reg + 27'h0000001;
		count_next = count_reg;
		if (interval_end) begin
			count_next = (bcast_block_valid && storm_threshold != 11'h000) ? 11'h001 : 11'h000;
		end else if (bcast_block_valid && count_reg < storm_threshold) begin
			count_next = count_reg + 11'h001;
		end
		limited_next = count_next >= storm_threshold;
		vid_valid_next = tag_valid;
		vid_next = tag_vid;
		if (null_vid_replace_en && tag_vid == switch_global_control_pkg::NULL_VID) begin
			vid_next = port_default_vid;
		end
		led_next = 4'h0;
		case (led_mode)
			switch_global_control_pkg::LED_MODE_LINK_ACT: begin
				led_next = {1'b0, link_up & ~activity, full_duplex | collision, speed_100};
			end
			switch_global_control_pkg::LED_MODE_SPEED_SPLIT: begin
				led_next = {1'b0, link_up & speed_100 & ~activity, link_up & ~speed_100 & ~activity,
					full_duplex};
			end
			default: begin
				led_next = 4'h0;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			timer_reg <= 27'h0000000;
			count_reg <= 11'h000;
			limited_reg <= 1'b0;
			vid_valid_reg <= 1'b0;
			vid_reg <= 12'h000;
			led_reg <= 4'h0;
		end else begin
			timer_reg <= timer_next;
			count_reg <= count_next;
			limited_reg <= limited_next;
			vid_valid_reg <= vid_valid_next;
			vid_reg <= vid_next;
			led_reg <= led_next;
		end
	end

	assign storm_limited = limited_reg;
	assign vid_out_valid = vid_valid_reg;
	assign vid_out = vid_reg;
	assign port_indicator_0 = led_reg[0];
	assign port_indicator_1 = led_reg[1];
	assign port_indicator_2 = led_reg[2];
	assign port_indicator_3 = led_reg[3];

	property p_storm_count_bound;
		@(posedge core_clk) disable iff (!reset_n)
		count_reg != $past(count_reg) |-> count_reg <= $past(storm_threshold);
	endproperty
	a_storm_count_bound: assert property (p_storm_count_bound) else $error("storm count above threshold");

	property p_interval_restart;
		@(posedge core_clk) disable iff (!reset_n)
		interval_end |=> timer_reg == 27'h0000000 && count_reg <= 11'h001;
	endproperty
	a_interval_restart: assert property (p_interval_restart) else $error("interval did not restart");

	property p_null_vid;
		@(posedge core_clk) disable iff (!reset_n)
		(tag_valid && null_vid_replace_en && tag_vid == 12'h000) |=> vid_out_valid && vid_out == $past(port_default_vid);
	endproperty
	a_null_vid: assert property (p_null_vid) else $error("null VLAN ID not replaced");

	property p_vid_kept;
		@(posedge core_clk) disable iff (!reset_n)
		(tag_valid && !null_vid_replace_en) |=> vid_out == $past(tag_vid);
	endproperty
	a_vid_kept: assert property (p_vid_kept) else $error("VLAN ID changed while replacement off");

	property p_led_speed_split;
		@(posedge core_clk) disable iff (!reset_n)
		(led_mode == switch_global_control_pkg::LED_MODE_SPEED_SPLIT && link_up && !activity)
			|=> port_indicator_2 == $past(speed_100) && port_indicator_1 == !$past(speed_100);
	endproperty
	a_led_speed_split: assert property (p_led_speed_split) else $error("LED speed split wrong");

	c_storm_limited: cover property (@(posedge core_clk) disable iff (!reset_n) $rose(storm_limited));
	c_null_vid: cover property (@(posedge core_clk) disable iff (!reset_n)
		tag_valid && null_vid_replace_en && tag_vid == 12'h000);
endmodule

// ---- switch_global_control_regs.sv ----
// Global switch control register bank with per-port storm, VLAN and LED logic.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ns
module switch_global_control_regs #(
	parameter int NUM_PORTS = 2,
	parameter int INTERVAL_100M_CYCLES = switch_global_control_pkg::STORM_INTERVAL_100M_CYCLES,
	parameter int INTERVAL_10M_CYCLES = switch_global_control_pkg::STORM_INTERVAL_10M_CYCLES
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wr_data,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	output logic [15:0] reg_rd_data,
	output logic repeater_mode_en,
	output logic host_port_half_duplex,
	output logic host_port_flow_ctrl_en,
	output logic [15:0] factory_test_value,
	input wire logic [NUM_PORTS-1:0] link_up,
	input wire logic [NUM_PORTS-1:0] speed_100,
	input wire logic [NUM_PORTS-1:0] full_duplex,
	input wire logic [NUM_PORTS-1:0] collision,
	input wire logic [NUM_PORTS-1:0] activity,
	input wire logic [NUM_PORTS-1:0] bcast_block_valid,
	output logic [NUM_PORTS-1:0] storm_limited,
	input wire logic [NUM_PORTS-1:0] tag_valid,
	input wire logic [NUM_PORTS-1:0][11:0] tag_vid,
	input wire logic [NUM_PORTS-1:0][11:0] port_default_vid,
	output logic [NUM_PORTS-1:0] vid_out_valid,
	output logic [NUM_PORTS-1:0][11:0] vid_out,
	output logic [NUM_PORTS-1:0] port_indicator_0,
	output logic [NUM_PORTS-1:0] port_indicator_1,
	output logic [NUM_PORTS-1:0] port_indicator_2,
	output logic [NUM_PORTS-1:0] port_indicator_3
);
	logic [15:0] storm_repeater_host_port_control_reg;
	logic [15:0] storm_repeater_host_port_control_next;
	logic [15:0] factory_test_control_reg;
	logic [15:0] factory_test_control_next;
	logic [15:0] led_mode_chip_control_reg;
	logic [15:0] led_mode_chip_control_next;
	logic [15:0] rd_data_reg;
	logic [15:0] rd_data_next;
	logic [10:0] storm_threshold;
	logic null_vid_replace_en;
	logic led_mode_select_high;
	logic led_mode_select_low;
	switch_global_control_pkg::led_mode_type led_mode;

	// Register writes land in one cycle so the new setting steers the port logic immediately.
	always_comb begin
		storm_repeater_host_port_control_next = storm_repeater_host_port_control_reg;
		factory_test_control_next = factory_test_control_reg;
		led_mode_chip_control_next = led_mode_chip_control_reg;
		if (reg_wr_en) begin
			if (reg_addr == switch_global_control_pkg::STORM_REPEATER_HOST_PORT_CONTROL_OFFSET) begin
				storm_repeater_host_port_control_next = reg_wr_data;
			end else if (reg_addr == switch_global_control_pkg::FACTORY_TEST_CONTROL_OFFSET) begin
				// Stored as written; keeping the reset value is up to software.
				factory_test_control_next = reg_wr_data;
			end else if (reg_addr == switch_global_control_pkg::LED_MODE_CHIP_CONTROL_OFFSET) begin
				// The low nine bits are read-only and keep their reset pattern.
				led_mode_chip_control_next = (reg_wr_data & switch_global_control_pkg::LED_MODE_WRITE_MASK) |
					(led_mode_chip_control_reg & ~switch_global_control_pkg::LED_MODE_WRITE_MASK);
			end
		end
	end

	// Read data are valid only in the cycle after the strobe; zero otherwise and for unmapped addresses.
	always_comb begin
		rd_data_next = 16'h0000;
		if (reg_rd_en) begin
			if (reg_addr == switch_global_control_pkg::STORM_REPEATER_HOST_PORT_CONTROL_OFFSET) begin
				rd_data_next = storm_repeater_host_port_control_reg;
			end else if (reg_addr == switch_global_control_pkg::FACTORY_TEST_CONTROL_OFFSET) begin
				rd_data_next = factory_test_control_reg;
			end else if (reg_addr == switch_global_control_pkg::LED_MODE_CHIP_CONTROL_OFFSET) begin
				rd_data_next = led_mode_chip_control_reg;
			end else if (reg_addr == switch_global_control_pkg::PORT_STORM_STATUS_OFFSET) begin
				rd_data_next = 16'(storm_limited);
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			storm_repeater_host_port_control_reg <=
				switch_global_control_pkg::STORM_REPEATER_HOST_PORT_CONTROL_RESET;
			factory_test_control_reg <= switch_global_control_pkg::FACTORY_TEST_CONTROL_RESET;
			led_mode_chip_control_reg <= switch_global_control_pkg::LED_MODE_CHIP_CONTROL_RESET;
			rd_data_reg <= 16'h0000;
		end else begin
			storm_repeater_host_port_control_reg <= storm_repeater_host_port_control_next;
			factory_test_control_reg <= factory_test_control_next;
			led_mode_chip_control_reg <= led_mode_chip_control_next;
			rd_data_reg <= rd_data_next;
		end
	end

	assign reg_rd_data = rd_data_reg;

	// The threshold is assembled from the high field and low byte.
	assign storm_threshold = {
		storm_repeater_host_port_control_reg[switch_global_control_pkg::STORM_HIGH_MSB:0],
		storm_repeater_host_port_control_reg[switch_global_control_pkg::STORM_LOW_MSB:
			switch_global_control_pkg::STORM_LOW_LSB]};
	// Repeater mode is only a control level here; speed and duplex limits are software's to keep.
	assign repeater_mode_en =
		storm_repeater_host_port_control_reg[switch_global_control_pkg::REPEATER_MODE_BIT];
	assign host_port_half_duplex =
		storm_repeater_host_port_control_reg[switch_global_control_pkg::HOST_HALF_DUPLEX_BIT];
	assign host_port_flow_ctrl_en =
		storm_repeater_host_port_control_reg[switch_global_control_pkg::HOST_FLOW_CONTROL_BIT];
	assign null_vid_replace_en =
		storm_repeater_host_port_control_reg[switch_global_control_pkg::NULL_VID_REPLACE_BIT];
	assign factory_test_value = factory_test_control_reg;
	assign led_mode_select_high = led_mode_chip_control_reg[switch_global_control_pkg::LED_MODE_SELECT_HIGH_BIT];
	assign led_mode_select_low = led_mode_chip_control_reg[switch_global_control_pkg::LED_MODE_SELECT_LOW_BIT];
	assign led_mode = switch_global_control_pkg::led_mode_type'({led_mode_select_high, led_mode_select_low});

	genvar port_index;
	generate
		for (port_index = 0; port_index < NUM_PORTS; port_index = port_index + 1) begin : g_port
			port_ctrl #(
				.INTERVAL_100M_CYCLES(INTERVAL_100M_CYCLES),
				.INTERVAL_10M_CYCLES(INTERVAL_10M_CYCLES)
			) u_port_ctrl (
				.core_clk(core_clk),
				.reset_n(reset_n),
				.storm_threshold(storm_threshold),
				.null_vid_replace_en(null_vid_replace_en),
				.led_mode(led_mode),
				.link_up(link_up[port_index]),
				.speed_100(speed_100[port_index]),
				.full_duplex(full_duplex[port_index]),
				.collision(collision[port_index]),
				.activity(activity[port_index]),
				.bcast_block_valid(bcast_block_valid[port_index]),
				.tag_valid(tag_valid[port_index]),
				.tag_vid(tag_vid[port_index]),
				.port_default_vid(port_default_vid[port_index]),
				.storm_limited(storm_limited[port_index]),
				.vid_out_valid(vid_out_valid[port_index]),
				.vid_out(vid_out[port_index]),
				.port_indicator_0(port_indicator_0[port_index]),
				.port_indicator_1(port_indicator_1[port_index]),
				.port_indicator_2(port_indicator_2[port_index]),
				.port_indicator_3(port_indicator_3[port_index])
			);
		end
	endgenerate

	property p_threshold_write;
		@(posedge core_clk) disable iff (!reset_n)
		(reg_wr_en && reg_addr == 16'h0406) |=> storm_threshold == {$past(reg_wr_data[2:0]), $past(reg_wr_data[15:8])};
	endproperty
	a_threshold_write: assert property (p_threshold_write) else $error("storm threshold not taken from write");

	property p_repeater_write;
		@(posedge core_clk) disable iff (!reset_n)
		(reg_wr_en && reg_addr == 16'h0406) |=> repeater_mode_en == $past(reg_wr_data[7]);
	endproperty
	a_repeater_write: assert property (p_repeater_write) else $error("repeater mode not following bit 7");

	property p_duplex_hold;
		@(posedge core_clk) disable iff (!reset_n)
		!(reg_wr_en && reg_addr == 16'h0406) |=> $stable(host_port_half_duplex);
	endproperty
	a_duplex_hold: assert property (p_duplex_hold) else $error("host duplex changed without write");

	property p_flow_write;
		@(posedge core_clk) disable iff (!reset_n)
		(reg_wr_en && reg_addr == 16'h0406) ##1 !(reg_wr_en && reg_addr == 16'h0406)
			|=> host_port_flow_ctrl_en == $past(reg_wr_data[5], 2);
	endproperty
	a_flow_write: assert property (p_flow_write) else $error("host flow control not following bit 5");

	property p_led_mode_write;
		@(posedge core_clk) disable iff (!reset_n)
		(reg_wr_en && reg_addr == 16'h040a) |=> led_mode == {$past(reg_wr_data[15]), $past(reg_wr_data[9])};
	endproperty
	a_led_mode_write: assert property (p_led_mode_write) else $error("LED mode not from bits 15 and 9");

	property p_readback;
		@(posedge core_clk) disable iff (!reset_n)
		(reg_wr_en && reg_addr == 16'h0408) ##1 (reg_rd_en && reg_addr == 16'h0408)
			|=> reg_rd_data == $past(reg_wr_data, 2);
	endproperty
	a_readback: assert property (p_readback) else $error("read did not return last written value");

	property p_idle_read_zero;
		@(posedge core_clk) disable iff (!reset_n)
		!reg_rd_en |=> reg_rd_data == 16'h0000;
	endproperty
	a_idle_read_zero: assert property (p_idle_read_zero) else $error("read data outside answer cycle");

	c_repeater_on: cover property (@(posedge core_clk) disable iff (!reset_n) $rose(repeater_mode_en));
	c_led_split: cover property (@(posedge core_clk) disable iff (!reset_n)
		led_mode == switch_global_control_pkg::LED_MODE_SPEED_SPLIT);
	c_readback: cover property (@(posedge core_clk) disable iff (!reset_n)
		(reg_wr_en && reg_addr == 16'h0406) ##1 (reg_rd_en && reg_addr == 16'h0406));
endmodule

// ---- tb.sv ----
// Self-checking testbench for the global switch control register bank.
`timescale 1ns/1ns
module tb;
	localparam int NP = 2;
	localparam int I100 = 20;
	localparam int I10 = 200;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [15:0] reg_wr_data = 16'h0000;
	logic reg_wr_en = 1'b0;
	logic reg_rd_en = 1'b0;
	logic [15:0] reg_rd_data;
	logic repeater_mode_en;
	logic host_port_half_duplex;
	logic host_port_flow_ctrl_en;
	logic [15:0] factory_test_value;
	logic [NP-1:0] link_up = 2'h0;
	logic [NP-1:0] speed_100 = 2'h3;
	logic [NP-1:0] full_duplex = 2'h0;
	logic [NP-1:0] collision = 2'h0;
	logic [NP-1:0] activity = 2'h0;
	logic [NP-1:0] bcast_block_valid = 2'h0;
	logic [NP-1:0] storm_limited;
	logic [NP-1:0] tag_valid = 2'h0;
	logic [NP-1:0][11:0] tag_vid = '0;
	logic [NP-1:0][11:0] port_default_vid = '0;
	logic [NP-1:0] vid_out_valid;
	logic [NP-1:0][11:0] vid_out;
	logic [NP-1:0] port_indicator_0;
	logic [NP-1:0] port_indicator_1;
	logic [NP-1:0] port_indicator_2;
	logic [NP-1:0] port_indicator_3;
	int err_count = 0;
	int checked = 0;
	logic [15:0] seed = 16'h0046;
	logic [15:0] d;
	int n;

	switch_global_control_regs #(
		.NUM_PORTS(NP), .INTERVAL_100M_CYCLES(I100), .INTERVAL_10M_CYCLES(I10)
	) i_switch_global_control_regs (
		.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
		.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
		.repeater_mode_en(repeater_mode_en), .host_port_half_duplex(host_port_half_duplex),
		.host_port_flow_ctrl_en(host_port_flow_ctrl_en), .factory_test_value(factory_test_value),
		.link_up(link_up), .speed_100(speed_100), .full_duplex(full_duplex), .collision(collision),
		.activity(activity), .bcast_block_valid(bcast_block_valid), .storm_limited(storm_limited),
		.tag_valid(tag_valid), .tag_vid(tag_vid), .port_default_vid(port_default_vid),
		.vid_out_valid(vid_out_valid), .vid_out(vid_out), .port_indicator_0(port_indicator_0),
		.port_indicator_1(port_indicator_1), .port_indicator_2(port_indicator_2), .port_indicator_3(port_indicator_3)
	);

	initial begin
		forever #5 core_clk = ~core_clk;
	end

	function automatic logic [15:0] lfsr(logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic logic [11:0] vid_exp(logic en, logic [11:0] tv, logic [11:0] dv);
		return (en && tv == 12'h000) ? dv : tv;
	endfunction

	// Indicator order is {3, 2, 1, 0}; the two upper codes leave every indicator dark by design choice.
	function automatic logic [3:0] led_exp(logic [1:0] code, logic lk, logic sp, logic dx, logic cl, logic ac);
		case (code)
			2'h0: return {1'b0, lk & ~ac, dx | cl, sp};
			2'h1: return {1'b0, lk & sp & ~ac, lk & ~sp & ~ac, dx};
			default: return 4'h0;
		endcase
	endfunction

	task automatic conclude();
		if (err_count == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// A write leaves its strobe up; the read that always follows lowers it, giving back-to-back strobes.
	task automatic wr(logic [15:0] a, logic [15:0] v);
		@(posedge core_clk);
		reg_wr_en <= 1'b1;
		reg_addr <= a;
		reg_wr_data <= v;
	endtask

	task automatic rd(logic [15:0] a, logic [15:0] exp);
		@(posedge core_clk);
		reg_wr_en <= 1'b0;
		reg_rd_en <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd_en <= 1'b0;
		#1;
		check("reg_rd_data", reg_rd_data, exp);
	endtask

	task automatic wait_lim(logic v, int bound);
		n = 0;
		while (storm_limited[0] !== v) begin
			if (n == bound) begin
				err_count++;
				conclude();
			end
			@(posedge core_clk);
			#1;
			n++;
		end
	endtask

	initial begin
		#400000;
		err_count++;
		conclude();
	end

	initial begin
		repeat (5) @(posedge core_clk);
		#1;
		check("repeater_mode_en", 16'(repeater_mode_en), 16'h0000);
		check("host_port_half_duplex", 16'(host_port_half_duplex), 16'h0000);
		check("host_port_flow_ctrl_en", 16'(host_port_flow_ctrl_en), 16'h0001);
		check("factory_test_value", factory_test_value, 16'h2400);
		@(posedge core_clk);
		reset_n <= 1'b1;
		rd(16'h0406, 16'h6320);
		rd(16'h0408, 16'h2400);
		rd(16'h040a, 16'h0835);
		for (int i = 0; i < 10; i++) begin
			seed = lfsr(seed);
			d = (i == 0) ? 16'h00a0 : (i == 1) ? 16'hffef : (i == 2) ? 16'h0000 : seed & 16'hffef;
			// Ports stay at 100 Mb/s half duplex here, so repeater mode may be switched on.
			wr(16'h0406, d);
			rd(16'h0406, d);
			check("repeater_mode_en", 16'(repeater_mode_en), 16'(d[7]));
			check("host_port_half_duplex", 16'(host_port_half_duplex), 16'(d[6]));
			check("host_port_flow_ctrl_en", 16'(host_port_flow_ctrl_en), 16'(d[5]));
		end
		wr(16'h0408, seed);
		rd(16'h0408, seed);
		check("factory_test_value", factory_test_value, seed);
		wr(16'h0408, 16'h2400);
		rd(16'h0408, 16'h2400);
		wr(16'h0500, 16'hffff);
		rd(16'h0500, 16'h0000);
		rd(16'h0407, 16'h0000);
		@(posedge core_clk);
		#1;
		check("reg_rd_data idle", reg_rd_data, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			wr(16'h0406, (i < 4) ? 16'h6328 : 16'h6320);
			rd(16'h0406, (i < 4) ? 16'h6328 : 16'h6320);
			seed = lfsr(seed);
			@(posedge core_clk);
			tag_valid <= 2'h3;
			tag_vid[0] <= (i % 2 == 0) ? 12'h000 : seed[11:0];
			tag_vid[1] <= (i % 2 == 0) ? seed[15:4] : 12'h000;
			port_default_vid[0] <= ~seed[11:0];
			port_default_vid[1] <= seed[12:1];
			@(posedge core_clk);
			tag_valid <= 2'h0;
			#1;
			check("vid_out_valid", 16'(vid_out_valid), 16'h0003);
			for (int p = 0; p < NP; p++) begin
				check("vid_out", 16'(vid_out[p]), 16'(vid_exp(i < 4, tag_vid[p], port_default_vid[p])));
			end
		end
		for (int c = 0; c < 4; c++) begin
			for (int k = 0; k < 3; k++) begin
				seed = lfsr(seed);
				d = (seed & 16'h7dff) | (16'(c[1]) << 15) | (16'(c[0]) << 9);
				wr(16'h040a, d);
				rd(16'h040a, (d & 16'hfe00) | 16'h0035);
				seed = lfsr(seed);
				@(posedge core_clk);
				{link_up, speed_100, full_duplex, collision, activity} <= seed[9:0];
				repeat (2) @(posedge core_clk);
				#1;
				for (int p = 0; p < NP; p++) begin
					check("port_indicators", 16'({port_indicator_3[p], port_indicator_2[p], port_indicator_1[p],
						port_indicator_0[p]}), 16'(led_exp(c[1:0], link_up[p], speed_100[p], full_duplex[p],
						collision[p], activity[p])));
				end
			end
		end
		@(posedge core_clk);
		speed_100 <= 2'h3;
		wr(16'h0406, 16'h0020);
		rd(16'h0406, 16'h0020);
		for (int i = 0; i < 2 * I100; i++) begin
			@(posedge core_clk);
			#1;
			check("storm_limited zero threshold", 16'(storm_limited), 16'h0003);
		end
		rd(16'h0440, 16'h0003);
		for (int s = 0; s < 2; s++) begin
			wr(16'h0406, 16'h0320);
			rd(16'h0406, 16'h0320);
			@(posedge core_clk);
			bcast_block_valid <= 2'h1;
			wait_lim(1'b1, 3 * I10);
			@(posedge core_clk);
			bcast_block_valid <= 2'h0;
			wait_lim(1'b0, I10 + 20);
			@(posedge core_clk);
			bcast_block_valid <= 2'h1;
			@(posedge core_clk);
			@(posedge core_clk);
			bcast_block_valid <= 2'h0;
			@(posedge core_clk);
			#1;
			check("storm_limited below", 16'(storm_limited), 16'h0000);
			@(posedge core_clk);
			bcast_block_valid <= 2'h1;
			@(posedge core_clk);
			bcast_block_valid <= 2'h0;
			@(posedge core_clk);
			#1;
			check("storm_limited at", 16'(storm_limited), 16'h0001);
			wait_lim(1'b0, I10 + 20);
			check("interval length", 16'(n > ((s == 0) ? I100 - 12 : I10 - 12) && n <= ((s == 0) ? I100 : I10)),
				16'h0001);
			@(posedge core_clk);
			speed_100 <= 2'h0;
		end
		conclude();
	end
endmodule
